/* File: logic/slsup_cfg.svh */
// Register map, field positions, reset values and codes of the signal limit supervisor.
`ifndef SLSUP_CFG_SVH
`define SLSUP_CFG_SVH

`define SLSUP_NFUNC         6
`define SLSUP_STATUS_OFF    8'h00
`define SLSUP_ISTAT_OFF     8'h04
`define SLSUP_ICLR_OFF      8'h08
`define SLSUP_IEN_OFF       8'h0C
`define SLSUP_FUNC_BASE     8'h10
`define SLSUP_FUNC_END      8'h70
`define SLSUP_CTRL_SUB      2'h0
`define SLSUP_LOW_SUB       2'h1
`define SLSUP_HIGH_SUB      2'h2
`define SLSUP_HYST_SUB      2'h3
`define SLSUP_MODE_LSB      0
`define SLSUP_ACT_LSB       4
`define SLSUP_SEL_LSB       8
`define SLSUP_MODE_RST      3'h0
`define SLSUP_ACT_RST       2'h0
`define SLSUP_SEL_RST       5'h03
`define SLSUP_LIM_RST       16'h0000
`define SLSUP_IEN_RST       8'h00
`define SLSUP_WARN_CODE     16'hA8B0
`define SLSUP_FAULT_CODE    16'h80B0
`define SLSUP_IRQ_WARN_BIT  6
`define SLSUP_IRQ_FAULT_BIT 7
`define SLSUP_SRC_ZERO      5'h00
`define SLSUP_SRC_SPEED     5'h01
`define SLSUP_SRC_FREQ      5'h03
`define SLSUP_SRC_CURR      5'h04
`define SLSUP_SRC_TORQ      5'h06
`define SLSUP_SRC_DCV       5'h07
`define SLSUP_SRC_POWER     5'h08
`define SLSUP_SRC_AI1       5'h09
`define SLSUP_SRC_AI2       5'h0A

`endif

/* File: logic/slsup_pkg.sv */
// Types and shared arithmetic of the signal limit supervisor.
package slsup_pkg;
`include "slsup_cfg.svh"

  typedef logic signed [15:0] slsup_sig_t;

  typedef enum logic [2:0] {
    SLSUP_MODE_OFF   = 3'h0,
    SLSUP_MODE_LOW   = 3'h1,
    SLSUP_MODE_HIGH  = 3'h2,
    SLSUP_MODE_ALOW  = 3'h3,
    SLSUP_MODE_AHIGH = 3'h4,
    SLSUP_MODE_BOTH  = 3'h5,
    SLSUP_MODE_ABOTH = 3'h6,
    SLSUP_MODE_HYST  = 3'h7
  } slsup_mode_e;

  typedef enum logic [1:0] {
    SLSUP_ACT_NONE      = 2'h0,
    SLSUP_ACT_WARN      = 2'h1,
    SLSUP_ACT_FAULT     = 2'h2,
    SLSUP_ACT_FAULT_RUN = 2'h3
  } slsup_act_e;

  typedef struct packed {
    slsup_mode_e mode;
    slsup_act_e  act;
    logic [4:0]  sel;
    slsup_sig_t  low;
    slsup_sig_t  high;
    logic [15:0] hyst;
  } slsup_fcfg_s;

  typedef struct packed {
    slsup_fcfg_s [5:0] cfg;
    logic [5:0]        cond_prev;
    logic [7:0]        istat;
    logic [7:0]        ien;
    logic              warn;
    logic              fault;
    logic [15:0]       wcode;
    logic [15:0]       fcode;
  } slsup_top_s;

  typedef struct packed {
    logic cond;
  } slsup_cmp_s;

  // Twice the value, so that half the hysteresis stays exact.
  function automatic logic signed [18:0] slsup_dbl(input slsup_sig_t x);
    return {x[15], x[15], x, 1'b0};
  endfunction

  // Twice the magnitude of the value.
  function automatic logic signed [18:0] slsup_abs2(input slsup_sig_t x);
    logic signed [18:0] d;
    d = slsup_dbl(x);
    return d[18] ? -d : d;
  endfunction

  // True for an aligned address inside the per-function register block.
  function automatic logic slsup_func_hit(input logic [7:0] a);
    return (a >= `SLSUP_FUNC_BASE) && (a < `SLSUP_FUNC_END) &&
           (a[1:0] == 2'h0);
  endfunction

endpackage

/* File: logic/slsup_sel.sv */
// Source selector that picks the monitored quantity of one function.
`timescale 1ns/1ps
`default_nettype none
`include "slsup_cfg.svh"
module slsup_sel (
  // Selector code
  input  wire logic [4:0]          sel,
  // Measured quantities
  input  wire slsup_pkg::slsup_sig_t sig_speed,
  input  wire slsup_pkg::slsup_sig_t sig_freq,
  input  wire slsup_pkg::slsup_sig_t sig_current,
  input  wire slsup_pkg::slsup_sig_t sig_torque,
  input  wire slsup_pkg::slsup_sig_t sig_dc_volt,
  input  wire slsup_pkg::slsup_sig_t sig_power,
  input  wire slsup_pkg::slsup_sig_t sig_ai1,
  input  wire slsup_pkg::slsup_sig_t sig_ai2,
  // Selected value
  output slsup_pkg::slsup_sig_t      value
);
  import slsup_pkg::*;

  always_comb begin
    unique case (sel)
      `SLSUP_SRC_SPEED: value = sig_speed;
      `SLSUP_SRC_FREQ:  value = sig_freq;
      `SLSUP_SRC_CURR:  value = sig_current;
      `SLSUP_SRC_TORQ:  value = sig_torque;
      `SLSUP_SRC_DCV:   value = sig_dc_volt;
      `SLSUP_SRC_POWER: value = sig_power;
      `SLSUP_SRC_AI1:   value = sig_ai1;
      `SLSUP_SRC_AI2:   value = sig_ai2;
      default:          value = 16'sh0000;
    endcase
  end

endmodule
`default_nettype wire

/* File: logic/slsup_cmp.sv */
// Limit comparator of one supervision function with its hysteresis state.
`timescale 1ns/1ps
`default_nettype none
module slsup_cmp (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Configuration and sample
  input  wire slsup_pkg::slsup_mode_e mode,
  input  wire slsup_pkg::slsup_sig_t  value,
  input  wire slsup_pkg::slsup_sig_t  low,
  input  wire slsup_pkg::slsup_sig_t  high,
  input  wire logic [15:0]            hyst,
  // Result
  output logic                        cond
);
  import slsup_pkg::*;

  slsup_cmp_s         r_reg;
  slsup_cmp_s         r_next;
  logic signed [18:0] v2;
  logic signed [18:0] a2;
  logic signed [18:0] lo2;
  logic signed [18:0] hi2;
  logic signed [18:0] h;

  always_comb begin
    v2     = slsup_dbl(value);
    a2     = slsup_abs2(value);
    lo2    = slsup_dbl(low);
    hi2    = slsup_dbl(high);
    h      = $signed({3'h0, hyst});
    r_next = r_reg;
    unique case (mode)
      SLSUP_MODE_OFF:   r_next.cond = 1'b0;
      SLSUP_MODE_LOW:   r_next.cond = v2 < lo2;
      SLSUP_MODE_HIGH:  r_next.cond = v2 > hi2;
      SLSUP_MODE_ALOW:  r_next.cond = a2 < lo2;
      SLSUP_MODE_AHIGH: r_next.cond = a2 > hi2;
      SLSUP_MODE_BOTH:  r_next.cond = (v2 < lo2) || (v2 > hi2);
      SLSUP_MODE_ABOTH: r_next.cond = (a2 < lo2) || (a2 > hi2);
      SLSUP_MODE_HYST:  r_next.cond = r_reg.cond ? !(v2 < hi2 - h)
                                                 : (v2 > hi2 + h);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cond = r_reg.cond;

endmodule
`default_nettype wire

/* File: logic/slsup_top.sv */
// Signal limit supervisor with six functions behind an APB slave.
// Functional notes
// - Status word bit n is high while function n's signal is outside limits.
// - Mode 0, the default, disables the function entirely.
// - Mode 1 flags a signal below the lower limit.
// - Mode 2 flags a signal above the upper limit.
// - Modes 3 and 4 compare the signal's magnitude against lower and upper.
// - Mode 5 flags below low or above high; mode 6 on magnitude.
// - Mode 7 sets above limit plus half hysteresis, clears below minus half.
// - Action 0 does nothing; action 1 raises warning code A8B0; default 0.
// - Action 2 raises fault code 80B0 whatever the run state.
// - Action 3 raises the fault only while the drive runs.
// - Status bits follow the comparison whatever action is chosen.
// - Action follows the met condition; mode, action, source set per function.
// - Each function picks its source; output frequency is the default.
// - Six independent functions, each with its own limits and response.
// - Source code 0 is zero, 1 speed, 3 frequency, 4 current.
`timescale 1ns/1ps
`default_nettype none
`include "slsup_cfg.svh"
module slsup_top (
  // APB slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Drive state and measured quantities
  input  wire logic                  drive_running,
  input  wire slsup_pkg::slsup_sig_t sig_speed,
  input  wire slsup_pkg::slsup_sig_t sig_freq,
  input  wire slsup_pkg::slsup_sig_t sig_current,
  input  wire slsup_pkg::slsup_sig_t sig_torque,
  input  wire slsup_pkg::slsup_sig_t sig_dc_volt,
  input  wire slsup_pkg::slsup_sig_t sig_power,
  input  wire slsup_pkg::slsup_sig_t sig_ai1,
  input  wire slsup_pkg::slsup_sig_t sig_ai2,
  // Supervision results
  output logic [15:0]                sup_status,
  output logic                       warn_active,
  output logic [15:0]                warn_code,
  output logic                       fault_active,
  output logic [15:0]                fault_code,
  output logic                       irq
);
  import slsup_pkg::*;

  slsup_top_s r_reg;
  slsup_top_s r_next;
  slsup_sig_t fval [`SLSUP_NFUNC];
  logic [5:0] cond;
  logic [5:0] warn_sel;
  logic [5:0] fault_sel;
  logic       wr;
  logic       acc;
  logic       fhit;
  logic [2:0] fidx;
  logic [1:0] sub;
  logic [7:0] clr;
  logic [7:0] ev;
  logic       warn_any;
  logic       fault_any;

  // Six identical functions, each a source selector and a comparator.
  for (genvar i = 0; i < `SLSUP_NFUNC; i++) begin : g_fn
    slsup_sel u_sel (
      .sel         (r_reg.cfg[i].sel),
      .sig_speed   (sig_speed),
      .sig_freq    (sig_freq),
      .sig_current (sig_current),
      .sig_torque  (sig_torque),
      .sig_dc_volt (sig_dc_volt),
      .sig_power   (sig_power),
      .sig_ai1     (sig_ai1),
      .sig_ai2     (sig_ai2),
      .value       (fval[i])
    );
    slsup_cmp u_cmp (
      .pclk    (pclk),
      .presetn (presetn),
      .mode    (r_reg.cfg[i].mode),
      .value   (fval[i]),
      .low     (r_reg.cfg[i].low),
      .high    (r_reg.cfg[i].high),
      .hyst    (r_reg.cfg[i].hyst),
      .cond    (cond[i])
    );
  end

  assign acc  = psel & penable;
  assign wr   = acc & pwrite;
  assign fhit = slsup_func_hit(paddr);
  assign fidx = 3'((paddr - `SLSUP_FUNC_BASE) >> 4);
  assign sub  = paddr[3:2];

  always_comb begin
    r_next = r_reg;
    clr    = 8'h00;
    for (int i = 0; i < `SLSUP_NFUNC; i++) begin
      warn_sel[i]  = r_reg.cfg[i].act == SLSUP_ACT_WARN;
      fault_sel[i] = (r_reg.cfg[i].act == SLSUP_ACT_FAULT) ||
                     ((r_reg.cfg[i].act == SLSUP_ACT_FAULT_RUN) &&
                      drive_running);
    end
    // Register writes.
    if (wr) begin
      if (paddr == `SLSUP_IEN_OFF) begin
        r_next.ien = pwdata[7:0];
      end else if (paddr == `SLSUP_ICLR_OFF) begin
        clr = pwdata[7:0];
      end else if (fhit) begin
        unique case (sub)
          `SLSUP_CTRL_SUB: begin
            r_next.cfg[fidx].mode =
              slsup_mode_e'(pwdata[`SLSUP_MODE_LSB +: 3]);
            r_next.cfg[fidx].act =
              slsup_act_e'(pwdata[`SLSUP_ACT_LSB +: 2]);
            r_next.cfg[fidx].sel = pwdata[`SLSUP_SEL_LSB +: 5];
          end
          `SLSUP_LOW_SUB:  r_next.cfg[fidx].low  = pwdata[15:0];
          `SLSUP_HIGH_SUB: r_next.cfg[fidx].high = pwdata[15:0];
          `SLSUP_HYST_SUB: r_next.cfg[fidx].hyst = pwdata[15:0];
        endcase
      end
    end
    // Actions follow the met conditions.
    warn_any        = |(cond & warn_sel);
    fault_any       = |(cond & fault_sel);
    r_next.warn     = warn_any;
    r_next.fault    = fault_any;
    r_next.wcode    = warn_any ? `SLSUP_WARN_CODE : 16'h0000;
    r_next.fcode    = fault_any ? `SLSUP_FAULT_CODE : 16'h0000;
    // Sticky event bits; a new event wins over a clear.
    ev              = {fault_any & ~r_reg.fault, warn_any & ~r_reg.warn,
                       cond & ~r_reg.cond_prev};
    r_next.cond_prev = cond;
    r_next.istat    = (r_reg.istat & ~clr) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `SLSUP_NFUNC; i++) begin
        r_reg.cfg[i].mode <= slsup_mode_e'(`SLSUP_MODE_RST);
        r_reg.cfg[i].act  <= slsup_act_e'(`SLSUP_ACT_RST);
        r_reg.cfg[i].sel  <= `SLSUP_SEL_RST;
        r_reg.cfg[i].low  <= `SLSUP_LIM_RST;
        r_reg.cfg[i].high <= `SLSUP_LIM_RST;
        r_reg.cfg[i].hyst <= `SLSUP_LIM_RST;
      end
      r_reg.cond_prev <= 6'h00;
      r_reg.istat     <= 8'h00;
      r_reg.ien       <= `SLSUP_IEN_RST;
      r_reg.warn      <= 1'b0;
      r_reg.fault     <= 1'b0;
      r_reg.wcode     <= 16'h0000;
      r_reg.fcode     <= 16'h0000;
    end else begin
      r_reg <= r_next;
    end
  end

  // Read data and error answer.
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == `SLSUP_STATUS_OFF) begin
      prdata  = {16'h0000, sup_status};
      pslverr = acc & pwrite;
    end else if (paddr == `SLSUP_ISTAT_OFF) begin
      prdata  = {24'h000000, r_reg.istat};
      pslverr = acc & pwrite;
    end else if (paddr == `SLSUP_ICLR_OFF) begin
      prdata  = 32'h0000_0000;
    end else if (paddr == `SLSUP_IEN_OFF) begin
      prdata  = {24'h000000, r_reg.ien};
    end else if (fhit) begin
      unique case (sub)
        `SLSUP_CTRL_SUB: begin
          prdata[`SLSUP_MODE_LSB +: 3] = r_reg.cfg[fidx].mode;
          prdata[`SLSUP_ACT_LSB +: 2]  = r_reg.cfg[fidx].act;
          prdata[`SLSUP_SEL_LSB +: 5]  = r_reg.cfg[fidx].sel;
        end
        `SLSUP_LOW_SUB:  prdata[15:0] = r_reg.cfg[fidx].low;
        `SLSUP_HIGH_SUB: prdata[15:0] = r_reg.cfg[fidx].high;
        `SLSUP_HYST_SUB: prdata[15:0] = r_reg.cfg[fidx].hyst;
      endcase
    end else begin
      pslverr = acc;
    end
  end

  assign pready       = 1'b1;
  assign sup_status   = {10'h000, cond};
  assign warn_active  = r_reg.warn;
  assign warn_code    = r_reg.wcode;
  assign fault_active = r_reg.fault;
  assign fault_code   = r_reg.fcode;
  assign irq          = |(r_reg.istat & r_reg.ien);

  // Checks on function 0 stand for all six, which share the same logic.
  slsup_fcfg_s        c0;
  logic signed [18:0] v0;
  logic               both0;
  logic               hidrop0;
  logic               hirise0;
  logic [5:0]         hardflt0;
  logic signed [18:0] a0;
  logic               aboth0;
  assign c0        = r_reg.cfg[0];
  assign v0        = slsup_dbl(fval[0]);
  assign both0     = (v0 < slsup_dbl(c0.low)) || (v0 > slsup_dbl(c0.high));
  assign hidrop0   = v0 < slsup_dbl(c0.high) - $signed({3'h0, c0.hyst});
  assign hirise0   = v0 > slsup_dbl(c0.high) + $signed({3'h0, c0.hyst});
  assign a0        = slsup_abs2(fval[0]);
  assign aboth0    = (a0 < slsup_dbl(c0.low)) || (a0 > slsup_dbl(c0.high));

  always_comb begin
    for (int i = 0; i < `SLSUP_NFUNC; i++) begin
      hardflt0[i] = r_reg.cfg[i].act == SLSUP_ACT_FAULT;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  status_word_a: assert property (acc && !pwrite &&
    paddr == `SLSUP_STATUS_OFF |-> prdata == {26'h0, cond})
    else $error("status word does not mirror the comparisons");
  mode_off_a: assert property (c0.mode == SLSUP_MODE_OFF
    |=> !cond[0]) else $error("disabled function flagged");
  low_mode_a: assert property (c0.mode == SLSUP_MODE_LOW &&
    fval[0] < c0.low |=> cond[0]) else $error("low mode missed");
  high_mode_a: assert property (c0.mode == SLSUP_MODE_HIGH &&
    fval[0] <= c0.high |=> !cond[0]) else $error("high mode false flag");
  abs_low_a: assert property (c0.mode == SLSUP_MODE_ALOW &&
    slsup_abs2(fval[0]) < slsup_dbl(c0.low) |=> cond[0])
    else $error("abs low mode missed");
  both_mode_a: assert property (c0.mode == SLSUP_MODE_BOTH
    |=> cond[0] == $past(both0)) else $error("both mode wrong");
  hyst_hold_a: assert property (c0.mode == SLSUP_MODE_HYST &&
    $past(c0.mode) == SLSUP_MODE_HYST && $past(cond[0]) &&
    !$past(hidrop0) |-> cond[0]) else $error("hysteresis released early");
  hyst_rise_a: assert property (c0.mode == SLSUP_MODE_HYST &&
    !cond[0] && !hirise0 |=> !cond[0]) else $error("hysteresis set early");
  warn_out_a: assert property (c0.act == SLSUP_ACT_WARN &&
    cond[0] |=> warn_active && warn_code == `SLSUP_WARN_CODE)
    else $error("warning not raised");
  fault_trip_a: assert property (c0.act == SLSUP_ACT_FAULT &&
    cond[0] |=> fault_active && fault_code == `SLSUP_FAULT_CODE)
    else $error("fault not raised");
  fault_stop_a: assert property ((cond & hardflt0) == 6'h00 &&
    !drive_running |=> !fault_active) else $error("fault while stopped");
  irq_sticky_a: assert property ($rose(cond[0]) && r_reg.ien[0]
    ##1 r_reg.ien[0] |-> irq) else $error("event did not interrupt");
  fault_run_a: assert property (c0.act == SLSUP_ACT_FAULT_RUN &&
    cond[0] && drive_running |=> fault_active &&
    fault_code == `SLSUP_FAULT_CODE) else $error("run fault missed");
  abs_high_a: assert property (c0.mode == SLSUP_MODE_AHIGH &&
    slsup_abs2(fval[0]) > slsup_dbl(c0.high) |=> cond[0])
    else $error("abs high mode missed");
  abs_both_a: assert property (c0.mode == SLSUP_MODE_ABOTH
    |=> cond[0] == $past(aboth0))
    else $error("abs both mode wrong");
  low_clear_a: assert property (c0.mode == SLSUP_MODE_LOW &&
    fval[0] >= c0.low |=> !cond[0])
    else $error("low mode false flag");
  high_set_a: assert property (c0.mode == SLSUP_MODE_HIGH &&
    fval[0] > c0.high |=> cond[0])
    else $error("high mode missed");
  no_action_a: assert property (c0.act == SLSUP_ACT_NONE &&
    c0.mode == SLSUP_MODE_HIGH && fval[0] > c0.high |=> sup_status[0])
    else $error("status bit hidden by action");
  quiet_none_a: assert property (c0.act == SLSUP_ACT_NONE &&
    cond == 6'h01 |=> !warn_active && !fault_active)
    else $error("no action still responded");
  code_idle_a: assert property (!warn_active && !fault_active
    |-> warn_code == 16'h0000 && fault_code == 16'h0000)
    else $error("event code without event");
  event_wins_a: assert property (ev[0]
    |=> r_reg.istat[0])
    else $error("event lost to a clear");
  ro_write_a: assert property (acc && pwrite &&
    paddr == `SLSUP_STATUS_OFF |-> pslverr)
    else $error("status write not refused");
  src_zero_a: assert property (r_reg.cfg[4].sel == `SLSUP_SRC_ZERO
    |-> fval[4] == 16'sh0000)
    else $error("zero source not zero");

  warn_cycle_c: cover property (warn_active ##1 !warn_active);
  run_fault_c: cover property (drive_running && fault_active);
  hyst_set_c: cover property (c0.mode == SLSUP_MODE_HYST && $rose(cond[0]));
  clear_race_c: cover property (wr && paddr == `SLSUP_ICLR_OFF && |ev);
  abs_both_c: cover property (c0.mode == SLSUP_MODE_ABOTH && $rose(cond[0]));

endmodule
`default_nettype wire

/* File: verif/slsup_fw_model.sv */
// Drive firmware model that supplies the run state and measured quantities.
`timescale 1ns/1ps
`default_nettype none
module slsup_fw_model (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Drive state and measured quantities
  output logic                  drive_running,
  output slsup_pkg::slsup_sig_t sig_speed,
  output slsup_pkg::slsup_sig_t sig_freq,
  output slsup_pkg::slsup_sig_t sig_current,
  output slsup_pkg::slsup_sig_t sig_torque,
  output slsup_pkg::slsup_sig_t sig_dc_volt,
  output slsup_pkg::slsup_sig_t sig_power,
  output slsup_pkg::slsup_sig_t sig_ai1,
  output slsup_pkg::slsup_sig_t sig_ai2
);
  import slsup_pkg::*;
  slsup_sig_t nxt [8] = '{default: 16'h0000};
  logic       run_nxt = 1'b0;
  // New values appear on the pins one edge after they are loaded.
  task automatic set_sig(input int idx, input slsup_sig_t v);
    nxt[idx] <= v;
  endtask
  task automatic set_run(input logic r);
    run_nxt <= r;
  endtask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sig_speed, sig_freq, sig_current, sig_torque} <= 64'h0;
      {sig_dc_volt, sig_power, sig_ai1, sig_ai2} <= 64'h0;
      drive_running <= 1'b0;
    end else begin
      {sig_speed, sig_freq, sig_current, sig_torque} <=
        {nxt[0], nxt[1], nxt[2], nxt[3]};
      {sig_dc_volt, sig_power, sig_ai1, sig_ai2} <=
        {nxt[4], nxt[5], nxt[6], nxt[7]};
      drive_running <= run_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: verif/slsup_top_test.sv */
// Self-checking testbench of the signal limit supervisor.
`timescale 1ns/1ps
`default_nettype none
module slsup_top_test;
  import slsup_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, drive_running, warn_active, fault_active;
  logic        irq;
  logic [15:0] sup_status, warn_code, fault_code;
  slsup_sig_t  s_speed, s_freq, s_curr, s_torq, s_dcv, s_pow, s_ai1, s_ai2;
  logic [33:0] rdq [$];
  logic [34:0] pinq [$];
  logic        chk_pins = 1'b0;
  int          n_errors = 0;
  int          check_count = 0;
  int          vals [14] = '{0, 49, 50, -49, -60, 200, 201, -201, 221, 220,
                             190, 179, 180, 230};
  int          codes [12] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 31};
  int          v;
  logic        c, hs;

  always #12.5 pclk = ~pclk;

  slsup_fw_model i_fw (.pclk(pclk), .presetn(presetn),
    .drive_running(drive_running), .sig_speed(s_speed), .sig_freq(s_freq),
    .sig_current(s_curr), .sig_torque(s_torq), .sig_dc_volt(s_dcv),
    .sig_power(s_pow), .sig_ai1(s_ai1), .sig_ai2(s_ai2));

  slsup_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_running(drive_running), .sig_speed(s_speed), .sig_freq(s_freq),
    .sig_current(s_curr), .sig_torque(s_torq), .sig_dc_volt(s_dcv),
    .sig_power(s_pow), .sig_ai1(s_ai1), .sig_ai2(s_ai2),
    .sup_status(sup_status), .warn_active(warn_active),
    .warn_code(warn_code), .fault_active(fault_active),
    .fault_code(fault_code), .irq(irq));

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic report(input string what, input logic [34:0] e,
                        input logic [34:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_rd(input logic [33:0] e);
    report("pslverr", {34'h0, e[32]}, {34'h0, pslverr});
    if (e[33] && !e[32]) begin
      report($sformatf("read %h", paddr), {3'h0, e[31:0]}, {3'h0, prdata});
    end
    if (e[33] && !e[32] && paddr == 8'h00) begin
      report("sup_status", {19'h0, e[15:0]}, {19'h0, sup_status});
    end
  endtask

  task automatic cmp_pins(input logic [34:0] e);
    report("outputs", e, {warn_active, warn_code, fault_active,
                          fault_code, irq});
  endtask

  // Notes are taken off the queues when a transfer or a pin check completes.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (rdq.size() == 0) n_errors++;
      else cmp_rd(rdq.pop_front());
    end
    if (chk_pins) cmp_pins(pinq.pop_front());
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    int k;
    rdq.push_back({~wr, err, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    apb(1'b1, a, d, err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    apb(1'b0, a, d, err);
  endtask

  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask

  task automatic fw(input int idx, input int val);
    i_fw.set_sig(idx, val[15:0]);
    settle();
  endtask

  task automatic pins(input logic w, input logic f, input logic q);
    pinq.push_back({w, w ? 16'hA8B0 : 16'h0000, f,
                    f ? 16'h80B0 : 16'h0000, q});
    @(posedge pclk);
    chk_pins <= 1'b1;
    @(posedge pclk);
    chk_pins <= 1'b0;
  endtask

  function automatic logic cond_of(input int m, input int x, inout logic h);
    int a;
    a = (x < 0) ? -x : x;
    case (m)
      1: return x < 50;
      2: return x > 200;
      3: return a < 50;
      4: return a > 200;
      5: return x < 50 || x > 200;
      6: return a < 50 || a > 200;
      7: begin
        if (2 * x > 440) h = 1'b1;
        else if (2 * x < 360) h = 1'b0;
        return h;
      end
      default: return 1'b0;
    endcase
  endfunction

  function automatic int src_idx(input int code);
    case (code)
      1: return 0;
      3: return 1;
      4: return 2;
      6: return 3;
      7: return 4;
      8: return 5;
      9: return 6;
      10: return 7;
      default: return -1;
    endcase
  endfunction

  initial begin
    repeat (90000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hC326));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h00000300);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h70, 32'h0, 1'b1);
    wr(8'h00, 32'h1, 1'b1);
    wr(8'h54, 32'd50);
    wr(8'h58, 32'd200);
    wr(8'h5C, 32'd40);
    rd(8'h58, 32'h000000C8);
    wr(8'h14, 32'd50);
    wr(8'h18, 32'd200);
    wr(8'h1C, 32'd40);
    hs = 1'b0;
    for (int m = 0; m < 8; m++) begin
      wr(8'h50, 32'h300 | m);
      wr(8'h10, 32'h300 | m);
      for (int i = 0; i < 18; i++) begin
        v = (i < 14) ? vals[i] : int'($urandom_range(600)) - 300;
        c = cond_of(m, v, hs);
        fw(1, v);
        rd(8'h00, {27'h0, c, 3'h0, c});
      end
    end
    wr(8'h58, 32'h0);
    wr(8'h10, 32'h300);
    foreach (codes[n]) begin
      wr(8'h50, 32'h2 | (codes[n] << 8));
      for (int j = 0; j < 8; j++) i_fw.set_sig(j, (j == src_idx(codes[n])) ?
                                               16'sd100 : -16'sd5);
      settle();
      rd(8'h00, {27'h0, src_idx(codes[n]) >= 0, 4'h0});
    end
    wr(8'h50, 32'h300);
    wr(8'h18, 32'h0);
    fw(0, 100);
    for (int act = 0; act < 4; act++) begin
      for (int r = 0; r < 2; r++) begin
        i_fw.set_run(r[0]);
        wr(8'h10, (act << 4) | 32'h102);
        settle();
        pins(act == 1, act == 2 || (act == 3 && r == 1), 1'b0);
        rd(8'h00, 32'h1);
      end
    end
    wr(8'h10, 32'h120);
    settle();
    pins(1'b0, 1'b0, 1'b0);
    wr(8'h08, 32'hFF);
    fw(0, -100);
    rd(8'h04, 32'h0);
    wr(8'h10, 32'h112);
    wr(8'h0C, 32'h41);
    rd(8'h0C, 32'h41);
    fw(0, 100);
    pins(1'b1, 1'b0, 1'b1);
    rd(8'h04, 32'h41);
    wr(8'h08, 32'h01);
    pins(1'b1, 1'b0, 1'b1);
    wr(8'h08, 32'h40);
    pins(1'b1, 1'b0, 1'b0);
    wr(8'h10, 32'h122);
    settle();
    pins(1'b0, 1'b1, 1'b0);
    rd(8'h04, 32'h80);
    print_verdict();
  end
endmodule
`default_nettype wire
